// ==== logic/sss_pkg.sv ====
`default_nettype none
package sss_pkg;
	// ************************************************
	// register map (byte addresses, 32-bit words)
	// ************************************************
	localparam logic [7:0]  SSS_OFS_CTRL     = 8'h00;      // command strobes, write only
	localparam logic [7:0]  SSS_OFS_SLOT_SEL = 8'h04;      // slot for load and save
	localparam logic [7:0]  SSS_OFS_BOOT_SEL = 8'h08;      // slot applied after reset
	localparam logic [7:0]  SSS_OFS_STATUS   = 8'h0C;      // busy, refused flag
	localparam logic [7:0]  SSS_OFS_WORK0    = 8'h10;      // first working settings word
	localparam logic [7:0]  SSS_OFS_WORK_END = 8'h1C;      // last working settings word

	// ************************************************
	// field positions
	// ************************************************
	localparam int          SSS_BIT_LOAD     = 0;          // ctrl: config_slot_load
	localparam int          SSS_BIT_SAVE     = 1;          // ctrl: config_slot_save
	localparam int          SSS_BIT_RESTART  = 2;          // ctrl: device_restart_cmd
	localparam int          SSS_BIT_BUSY     = 0;          // status: operation running
	localparam int          SSS_BIT_REFUSED  = 1;          // status: sticky refused command

	// ************************************************
	// slot codes and storage layout
	// ************************************************
	localparam logic [1:0]  SSS_SLOT_FACTORY = 2'h0;       // read-only factory slot
	localparam logic [1:0]  SSS_SLOT_USER1   = 2'h1;       // user_slot_one
	localparam logic [1:0]  SSS_SLOT_USER2   = 2'h2;       // user_slot_two
	localparam int          SSS_WORDS        = 4;          // words per settings slot
	localparam logic [2:0]  SSS_LAST_IDX     = 3'h3;       // index of last word in a slot
	localparam logic [2:0]  SSS_IDX_END      = 3'h4;       // index past the last word
	localparam logic [3:0]  SSS_BOOT_ADDR    = 4'hC;       // flash word holding boot slot
	localparam logic [31:0] SSS_FACTORY [0:SSS_WORDS-1] = '{32'h0000_0001, 32'h0000_2710,
	                                                         32'h0000_0000, 32'h0000_0000};

	// ************************************************
	// timing
	// ************************************************
	localparam logic [7:0]  SSS_RESTART_CYCLES = 8'h20;    // restart pulse length in clocks

	// ************************************************
	// controller states
	// ************************************************
	typedef enum logic [5:0] {
		SSS_IDLE    = 6'b000001,
		SSS_BOOTRD  = 6'b000010,
		SSS_LOAD    = 6'b000100,
		SSS_SAVE    = 6'b001000,
		SSS_BOOTWR  = 6'b010000,
		SSS_RESTART = 6'b100000
	} sss_state_t;

	// flash word address of a word in a slot
	function automatic logic [3:0] sss_slot_addr(input logic [1:0] slot, input logic [2:0] idx);
		sss_slot_addr = {slot, idx[1:0]};
	endfunction
endpackage
`default_nettype wire

// ==== logic/sss_flash_store.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// non-volatile slot store
// ************************************************
module sss_flash_store
	import sss_pkg::*;
(
	// clock
	input  wire logic        clk,
	// access port
	input  wire logic        we,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);
	logic [31:0] cells [0:15];   // user slots and boot word; no reset, survives restarts

	// blank flash reads as zero, so the boot word starts at the factory slot
	initial begin
		for (int i = 0; i < 16; i++) begin
			cells[i] = 32'h0000_0000;
		end
	end

	// writes into the factory slot are dropped here as a second guard
	always_ff @(posedge clk) begin
		if (we && addr[3:2] != SSS_SLOT_FACTORY) begin
			cells[addr] <= wdata;
		end
	end

	// registered read; factory slot comes from constants, not cells
	always_ff @(posedge clk) begin
		if (addr[3:2] == SSS_SLOT_FACTORY) begin
			rdata <= SSS_FACTORY[addr[1:0]];
		end else begin
			rdata <= cells[addr];
		end
	end
endmodule
`default_nettype wire

// ==== logic/sss_slot_store.sv ====
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module sss_slot_store
	import sss_pkg::*;
(
	// clock and reset
	input  wire logic         CLK_SYS,
	input  wire logic         RESET_N,
	// apb slave
	input  wire logic         PSEL,
	input  wire logic         PENABLE,
	input  wire logic         PWRITE,
	input  wire logic [7:0]   PADDR,
	input  wire logic [31:0]  PWDATA,
	output logic      [31:0]  PRDATA,
	output logic              PREADY,
	output logic              PSLVERR,
	// device side
	output logic      [127:0] WORK_SETTINGS,
	output logic              BUSY,
	output logic              HOST_LINK_UP,
	output logic              SYS_RESTART
);
	import sss_pkg::*;

	// ************************************************
	// declarations
	// ************************************************
	sss_state_t  state;                        // controller state
	logic [1:0]  slot_sel;                     // config_slot_select
	logic [1:0]  boot_sel;                     // shadow of boot_slot_select in flash
	logic [1:0]  op_slot;                      // slot of the running operation
	logic [2:0]  idx;                          // word counter within a slot
	logic        rvalid;                       // flash read data due this cycle
	logic [1:0]  ridx;                         // word index of that read
	logic [7:0]  rst_cnt;                      // restart hold counter
	logic        refused;                      // sticky refused-command flag
	logic [31:0] work [0:SSS_WORDS-1];         // working settings, volatile
	logic        mem_we;                       // flash write strobe
	logic [3:0]  mem_addr;                     // flash address
	logic [31:0] mem_wdata;                    // flash write data
	logic [31:0] mem_rdata;                    // flash read data, registered
	logic        apb_wr;                       // write completes at this edge
	logic        idle;                         // controller free for commands
	logic        hit_work;                     // address lands on a working word
	logic        hit_any;                      // address is mapped
	logic        refuse_evt;                   // a command was refused this edge
	logic        refused_clr;                  // software clears refused flag
	logic [31:0] next_rdata;                   // read data for the answer
	logic        restart_done;                 // last cycle of the restart hold

	// ************************************************
	// decode
	// ************************************************
	assign apb_wr   = PSEL && PENABLE && PREADY && PWRITE;
	assign idle     = (state == SSS_IDLE);
	// a restart ends like a power cycle, so the slot selector goes with it
	assign restart_done = (state == SSS_RESTART) && (rst_cnt == SSS_RESTART_CYCLES - 8'h01);
	assign hit_work = (PADDR >= SSS_OFS_WORK0) && (PADDR <= SSS_OFS_WORK_END) && (PADDR[1:0] == 2'h0);
	assign hit_any  = hit_work || PADDR == SSS_OFS_CTRL || PADDR == SSS_OFS_SLOT_SEL
	               || PADDR == SSS_OFS_BOOT_SEL || PADDR == SSS_OFS_STATUS;

	// load or save while busy, save to factory, and working-word or boot writes while busy are refused; illegal slot codes are dropped
	always_comb begin
		refuse_evt  = 1'b0;
		refused_clr = apb_wr && PADDR == SSS_OFS_STATUS && PWDATA[SSS_BIT_REFUSED];
		if (apb_wr && PADDR == SSS_OFS_CTRL) begin
			if (!idle && (PWDATA[SSS_BIT_LOAD] || PWDATA[SSS_BIT_SAVE])) begin
				refuse_evt = 1'b1;
			end else if (PWDATA[SSS_BIT_SAVE] && slot_sel == SSS_SLOT_FACTORY) begin
				refuse_evt = 1'b1;
			end
		end
		if (apb_wr && !idle && (hit_work || PADDR == SSS_OFS_BOOT_SEL)) begin
			refuse_evt = 1'b1;
		end
	end

	// ************************************************
	// flash port
	// ************************************************
	always_comb begin
		mem_we    = 1'b0;
		mem_addr  = sss_slot_addr(op_slot, idx);
		mem_wdata = work[idx[1:0]];
		unique case (state)
			SSS_BOOTRD: begin
				mem_addr = SSS_BOOT_ADDR;
			end
			SSS_SAVE: begin
				mem_we = 1'b1;
			end
			SSS_BOOTWR: begin
				mem_we    = 1'b1;
				mem_addr  = SSS_BOOT_ADDR;
				mem_wdata = {30'h0, boot_sel};
			end
			SSS_IDLE, SSS_LOAD, SSS_RESTART: begin
			end
		endcase
	end

	sss_flash_store u_flash (
		.clk   (CLK_SYS),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	// ************************************************
	// apb answer
	// ************************************************
	// read mux for the answer
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_work) begin
			next_rdata = work[PADDR[3:2]];
		end else if (PADDR == SSS_OFS_SLOT_SEL) begin
			next_rdata = {30'h0, slot_sel};
		end else if (PADDR == SSS_OFS_BOOT_SEL) begin
			next_rdata = {30'h0, boot_sel};
		end else if (PADDR == SSS_OFS_STATUS) begin
			next_rdata = {30'h0, refused, !idle};
		end
	end

	// no wait state: ready rises in the first access cycle
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end else begin
			PREADY  <= PSEL && !PREADY;
			PSLVERR <= PSEL && !PREADY && !hit_any;
			PRDATA  <= (PSEL && !PREADY && !PWRITE) ? next_rdata : 32'h0000_0000;
		end
	end

	// ************************************************
	// software settings
	// ************************************************
	// slot selector; code 3 is not a slot and is dropped
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			slot_sel <= SSS_SLOT_FACTORY;
		end else if (restart_done) begin
			slot_sel <= SSS_SLOT_FACTORY;
		end else if (apb_wr && PADDR == SSS_OFS_SLOT_SEL && PWDATA[1:0] <= SSS_SLOT_USER2) begin
			slot_sel <= PWDATA[1:0];
		end
	end

	// refused flag: a new refusal wins over a clear in the same edge
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			refused <= 1'b0;
		end else if (refuse_evt) begin
			refused <= 1'b1;
		end else if (refused_clr) begin
			refused <= 1'b0;
		end
	end

	// ************************************************
	// controller and working settings
	// ************************************************
	// reset starts with the boot read, so every reset reapplies the boot slot
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state    <= SSS_BOOTRD;
			op_slot  <= SSS_SLOT_FACTORY;
			boot_sel <= SSS_SLOT_FACTORY;
			idx      <= 3'h0;
			rvalid   <= 1'b0;
			ridx     <= 2'h0;
			rst_cnt  <= 8'h00;
			for (int i = 0; i < SSS_WORDS; i++) begin
				work[i] <= 32'h0000_0000;
			end
		end else begin
			unique case (state)
				SSS_IDLE: begin
					idx    <= 3'h0;
					rvalid <= 1'b0;
					if (apb_wr && hit_work) begin
						work[PADDR[3:2]] <= PWDATA;
					end else if (apb_wr && PADDR == SSS_OFS_BOOT_SEL && PWDATA[1:0] <= SSS_SLOT_USER2) begin
						boot_sel <= PWDATA[1:0];
						state    <= SSS_BOOTWR;
					end else if (apb_wr && PADDR == SSS_OFS_CTRL) begin
						// restart outranks load, load outranks save
						if (PWDATA[SSS_BIT_RESTART]) begin
							rst_cnt <= 8'h00;
							state   <= SSS_RESTART;
						end else if (PWDATA[SSS_BIT_LOAD]) begin
							op_slot <= slot_sel;
							state   <= SSS_LOAD;
						end else if (PWDATA[SSS_BIT_SAVE] && slot_sel != SSS_SLOT_FACTORY) begin
							op_slot <= slot_sel;
							state   <= SSS_SAVE;
						end
					end
				end
				SSS_BOOTRD: begin
					rvalid <= 1'b1;
					if (rvalid) begin
						// an unknown code falls back to the factory slot
						op_slot <= (mem_rdata[1:0] <= SSS_SLOT_USER2) ? mem_rdata[1:0] : SSS_SLOT_FACTORY;
						boot_sel <= (mem_rdata[1:0] <= SSS_SLOT_USER2) ? mem_rdata[1:0] : SSS_SLOT_FACTORY;
						rvalid  <= 1'b0;
						idx     <= 3'h0;
						state   <= SSS_LOAD;
					end
				end
				SSS_LOAD: begin
					if (idx != SSS_IDX_END) begin
						idx <= idx + 3'h1;
					end
					rvalid <= (idx != SSS_IDX_END);
					ridx   <= idx[1:0];
					if (rvalid) begin
						work[ridx] <= mem_rdata;
					end
					if (rvalid && idx == SSS_IDX_END) begin
						state <= SSS_IDLE;
					end
				end
				SSS_SAVE: begin
					idx <= idx + 3'h1;
					if (idx == SSS_LAST_IDX) begin
						state <= SSS_IDLE;
					end
				end
				SSS_BOOTWR: begin
					state <= SSS_IDLE;
				end
				SSS_RESTART: begin
					// hold, then clear the working settings and boot as from power-on; the refused flag is kept
					rst_cnt <= rst_cnt + 8'h01;
					if (rst_cnt == SSS_RESTART_CYCLES - 8'h01) begin
						for (int i = 0; i < SSS_WORDS; i++) begin
							work[i] <= 32'h0000_0000;
						end
						rvalid <= 1'b0;
						state  <= SSS_BOOTRD;
					end
				end
				default: begin
					state <= SSS_IDLE;
				end
			endcase
		end
	end

	// ************************************************
	// device outputs, registered
	// ************************************************
	// link stays down through restart and boot load so the host must reconnect
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			WORK_SETTINGS <= 128'h0;
			BUSY          <= 1'b1;
			HOST_LINK_UP  <= 1'b0;
			SYS_RESTART   <= 1'b0;
		end else begin
			WORK_SETTINGS <= {work[3], work[2], work[1], work[0]};
			BUSY          <= !idle;
			HOST_LINK_UP  <= idle || state == SSS_LOAD && HOST_LINK_UP
			              || state == SSS_SAVE || state == SSS_BOOTWR;
			SYS_RESTART   <= (state == SSS_RESTART);
		end
	end
endmodule
`default_nettype wire

// ==== verification/sss_slot_store_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module sss_slot_store_monitor
	import sss_pkg::*;
(
	// clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RESET_N,
	// apb
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// device side
	input wire logic        BUSY,
	input wire logic        HOST_LINK_UP,
	input wire logic        SYS_RESTART
);
	// ****
	// helpers
	// ****
	logic [7:0] hi_cnt;  // cycles the restart pin has stood high
	// an accepted load: idle controller, ctrl write with the load bit
	wire logic  ld_go = PSEL && PENABLE && PREADY && PWRITE && PADDR == SSS_OFS_CTRL
		&& PWDATA[SSS_BIT_LOAD] && !BUSY;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// counts the pulse so its length is judged at the falling edge
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) hi_cnt <= 8'h00;
		else hi_cnt <= SYS_RESTART ? hi_cnt + 8'h01 : 8'h00;
	end
	// ****
	// assertions
	// ****
	a_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("pready held past one cycle");
	a_ready_after_setup: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
		else $error("pready outside access phase");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("pslverr without pready");
	a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("prdata not zero outside answer");
	a_restart_length: assert property ($fell(SYS_RESTART) |-> hi_cnt == SSS_RESTART_CYCLES)
		else $error("restart pulse length wrong");
	a_link_down_restart: assert property (SYS_RESTART |-> !HOST_LINK_UP && BUSY)
		else $error("link up during restart");
	a_link_up_idle: assert property (!BUSY |-> HOST_LINK_UP)
		else $error("link down while idle");
	a_load_goes_busy: assert property (ld_go |-> ##[1:3] BUSY)
		else $error("load did not start");
	// ****
	// covers
	// ****
	c_load: cover property (ld_go);
	c_restart: cover property ($fell(SYS_RESTART));
	c_error: cover property (PSLVERR);
endmodule
bind sss_slot_store sss_slot_store_monitor mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY(BUSY), .HOST_LINK_UP(HOST_LINK_UP),
	.SYS_RESTART(SYS_RESTART));
`default_nettype wire

// ==== verification/sss_slot_store_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module sss_slot_store_tb;
	import sss_pkg::*;
	// ****
	// signals
	// ****
	logic         clk_sys = 1'h0;
	logic         rst_n, psel, penable, pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, q;
	logic         pready, pslverr, busy, link_up, sys_restart, e;
	logic [127:0] work;
	int           err_total = 0;
	int           checked = 0;
	// user words, chosen so every word differs from the factory set
	localparam logic [31:0]  W [0:3] = '{32'hA5A5_0001, 32'h5A5A_0002, 32'h0000_FFFF, 32'hFFFF_0000};
	localparam logic [127:0] FAC = {SSS_FACTORY[3], SSS_FACTORY[2], SSS_FACTORY[1], SSS_FACTORY[0]};
	localparam logic [127:0] USR = {W[3], W[2], W[1], W[0]};
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} sss_row_t;
	// write flag, address, write data, read expected, error expected
	sss_row_t rows [0:9] = '{'{1'h1, SSS_OFS_SLOT_SEL, 32'h2, 32'h2, 1'h0},
		'{1'h1, SSS_OFS_SLOT_SEL, 32'h3, 32'h2, 1'h0}, '{1'h1, SSS_OFS_SLOT_SEL, 32'h1, 32'h1, 1'h0},
		'{1'h1, SSS_OFS_WORK0, W[0], W[0], 1'h0}, '{1'h1, 8'h14, W[1], W[1], 1'h0},
		'{1'h1, 8'h18, W[2], W[2], 1'h0}, '{1'h1, SSS_OFS_WORK_END, W[3], W[3], 1'h0},
		'{1'h0, SSS_OFS_CTRL, 32'h0, 32'h0, 1'h0}, '{1'h0, SSS_OFS_STATUS, 32'h0, 32'h0, 1'h0},
		'{1'h1, 8'h20, 32'hF, 32'h0, 1'h1}};
	sss_slot_store dut (.CLK_SYS(clk_sys), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .WORK_SETTINGS(work), .BUSY(busy), .HOST_LINK_UP(link_up),
		.SYS_RESTART(sys_restart));
	// 40 mhz clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ****
	// tasks
	// ****
	task automatic chk(input string n, input logic [127:0] x, input logic [127:0] g);
		checked++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one apb transfer; answer is taken at the edge pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	// busy rises one edge after a command, so skip three edges first
	task automatic idle();
		int n;
		n = 0;
		repeat (3) @(posedge clk_sys);
		while (busy !== 1'h0 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 400) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	// ****
	// sequence
	// ****
	initial begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk_sys);
		chk("busy_in_reset", 128'h1, busy);
		chk("link_in_reset", 128'h0, link_up);
		rst_n <= 1'h1;
		idle();
		chk("boot_factory", FAC, work);
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			chk("row_data", rows[i].x, q);
			chk("row_err", rows[i].e, e);
		end
		chk("work_port", USR, work);
		// save to user one, then a load while it still runs
		apb(1'h1, SSS_OFS_CTRL, 32'h2);
		apb(1'h1, SSS_OFS_CTRL, 32'h1);
		apb(1'h0, SSS_OFS_STATUS, 32'h0);
		chk("refused_overlap", 128'h1, q[SSS_BIT_REFUSED]);
		idle();
		apb(1'h1, SSS_OFS_STATUS, 32'h2);
		apb(1'h0, SSS_OFS_STATUS, 32'h0);
		chk("refused_clear", 128'h0, q);
		apb(1'h1, SSS_OFS_WORK0, 32'h0);
		apb(1'h1, SSS_OFS_CTRL, 32'h1);
		idle();
		chk("load_user1", USR, work);
		// saving over the factory slot is refused
		apb(1'h1, SSS_OFS_SLOT_SEL, 32'h0);
		apb(1'h1, SSS_OFS_CTRL, 32'h2);
		idle();
		apb(1'h0, SSS_OFS_STATUS, 32'h0);
		chk("refused_factory", 128'h2, q);
		apb(1'h1, SSS_OFS_CTRL, 32'h1);
		idle();
		chk("load_factory", FAC, work);
		// boot from user one across a second reset
		apb(1'h1, SSS_OFS_BOOT_SEL, 32'h1);
		idle();
		rst_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		chk("work_cleared", 128'h0, work);
		rst_n <= 1'h1;
		idle();
		chk("boot_user1", USR, work);
		apb(1'h0, SSS_OFS_SLOT_SEL, 32'h0);
		chk("slot_volatile", 128'h0, q);
		// restart drops the link and reloads the boot slot
		apb(1'h1, SSS_OFS_SLOT_SEL, 32'h2);
		apb(1'h1, SSS_OFS_WORK0, 32'h0);
		apb(1'h1, SSS_OFS_CTRL, 32'h4);
		apb(1'h0, SSS_OFS_STATUS, 32'h0);
		chk("status_busy", 128'h1, q);
		repeat (4) @(posedge clk_sys);
		chk("restart_pin", 128'h1, sys_restart);
		chk("link_drop", 128'h0, link_up);
		idle();
		chk("restart_boot", USR, work);
		chk("link_back", 128'h1, link_up);
		apb(1'h0, SSS_OFS_SLOT_SEL, 32'h0);
		chk("slot_after_restart", 128'h0, q);
		tally_and_finish();
	end
endmodule
`default_nettype wire
